// ==== verilog/cdss_pkg.sv ====
package cdss_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] STAT_OFS   = 12'h004;
	localparam logic [11:0] IRQ_OFS    = 12'h008;
	localparam logic [11:0] MASK_OFS   = 12'h00c;
	localparam logic [11:0] EVT_OFS    = 12'h010;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int CTRL_MON_BIT  = 0;
	localparam int CTRL_POL_BIT  = 1;
	localparam int CTRL_BOOT_BIT = 2;
	localparam int CTRL_CRSH_BIT = 3;
	localparam int CTRL_SHUT_BIT = 4;
	localparam logic [4:0] CTRL_RST = 5'h01;

	// ----------------------------------------------------------------
	// Event register fields (write one to fire)
	// ----------------------------------------------------------------
	localparam int EVT_MSG_BIT   = 0;
	localparam int EVT_CLS2_BIT  = 1;
	localparam int EVT_READ_BIT  = 2;

	// ----------------------------------------------------------------
	// Interrupt fields
	// ----------------------------------------------------------------
	localparam int IRQ_INS_BIT = 0;
	localparam int IRQ_REM_BIT = 1;
	localparam int IRQ_MSG_BIT = 2;
	localparam int IRQ_W       = 3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int PULSE_MS     = 100;
	localparam int PULSE_CYC    = PULSE_MS * 1000 * CLK_MHZ;
	localparam int FILT_CYC     = 16;

	// ----------------------------------------------------------------
	// Card state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CDSS_ABSENT  = 2'b00,
		CDSS_INIT    = 2'b01,
		CDSS_PRESENT = 2'b11,
		CDSS_FROZEN  = 2'b10
	} cdss_card_t;

endpackage : cdss_pkg

// ==== verilog/cdss_top.sv ====
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
module cdss_top #(
	parameter int PULSE_CYCLES = cdss_pkg::PULSE_CYC,
	parameter int FILT_CYCLES  = cdss_pkg::FILT_CYC
) (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Card slot
	input  wire logic        card_detect_in_i,
	output logic             card_init_start_o,
	// Host status
	output logic             firmware_ready_out_o,
	output logic             message_arrival_pulse_out_o,
	output logic             irq_o
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [31:0]             prdata_ff;
	logic                    pready_ff;
	logic                    pslverr_ff;
	logic [4:0]              ctrl_ff;
	logic [cdss_pkg::IRQ_W-1:0] irq_st_ff;
	logic [cdss_pkg::IRQ_W-1:0] irq_mask_ff;
	logic                    irq_ff;

	wire        acc      = psel_i & penable_i & ~pready_ff;
	wire        wr_en    = acc & pwrite_i & pstrb_i[0];
	wire        sel_ctrl = paddr_i == cdss_pkg::CTRL_OFS;
	wire        sel_stat = paddr_i == cdss_pkg::STAT_OFS;
	wire        sel_irq  = paddr_i == cdss_pkg::IRQ_OFS;
	wire        sel_mask = paddr_i == cdss_pkg::MASK_OFS;
	wire        sel_evt  = paddr_i == cdss_pkg::EVT_OFS;
	wire        mapped   = sel_ctrl | sel_stat | sel_irq | sel_mask | sel_evt;
	wire        wr_ctrl  = wr_en & sel_ctrl;
	wire        wr_irq   = wr_en & sel_irq;
	wire        wr_mask  = wr_en & sel_mask;
	wire        wr_evt   = wr_en & sel_evt;

	wire mon_en   = ctrl_ff[cdss_pkg::CTRL_MON_BIT];
	wire pol_low  = ctrl_ff[cdss_pkg::CTRL_POL_BIT];
	wire boot_ok  = ctrl_ff[cdss_pkg::CTRL_BOOT_BIT];
	wire crashed  = ctrl_ff[cdss_pkg::CTRL_CRSH_BIT];
	wire shutdown = ctrl_ff[cdss_pkg::CTRL_SHUT_BIT];

	// Message events: bit0 received, bit1 marks class 2
	wire msg_evt  = wr_evt & pwdata_i[cdss_pkg::EVT_MSG_BIT];
	wire msg_cls2 = pwdata_i[cdss_pkg::EVT_CLS2_BIT];
	wire msg_fire = msg_evt & ~msg_cls2;
	wire read_req = wr_evt & pwdata_i[cdss_pkg::EVT_READ_BIT];

	// ----------------------------------------------------------------
	// Detect synchroniser and filter
	// ----------------------------------------------------------------
	logic        cd_s1_ff;
	logic        cd_s2_ff;
	logic        cd_filt_ff;
	logic [15:0] filt_cnt_ff;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cd_s1_ff <= 1'b0;
			cd_s2_ff <= 1'b0;
		end else begin
			cd_s1_ff <= card_detect_in_i;
			cd_s2_ff <= cd_s1_ff;
		end
	end

	wire        filt_diff = cd_s2_ff != cd_filt_ff;
	wire        filt_done = filt_cnt_ff == 16'(FILT_CYCLES - 1);
	wire [15:0] nxt_filt_cnt = filt_diff ? (filt_done ? 16'h0000 : filt_cnt_ff + 16'h0001)
	                                     : 16'h0000;
	wire        nxt_cd_filt = (filt_diff & filt_done) ? cd_s2_ff : cd_filt_ff;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			filt_cnt_ff <= 16'h0000;
			cd_filt_ff  <= 1'b0;
		end else begin
			filt_cnt_ff <= nxt_filt_cnt;
			cd_filt_ff  <= nxt_cd_filt;
		end
	end

	wire present = cd_filt_ff ^ pol_low;

	// ----------------------------------------------------------------
	// Card state machine
	// ----------------------------------------------------------------
	cdss_pkg::cdss_card_t card_ff;
	cdss_pkg::cdss_card_t nxt_card;
	logic                 started_ff;
	logic                 init_ff;

	always_comb begin
		nxt_card = card_ff;
		case (card_ff)
			cdss_pkg::CDSS_ABSENT: begin
				if (!mon_en && started_ff)
					nxt_card = cdss_pkg::CDSS_FROZEN;
				else if (present && (mon_en || !started_ff))
					nxt_card = cdss_pkg::CDSS_INIT;
			end
			cdss_pkg::CDSS_INIT: begin
				nxt_card = cdss_pkg::CDSS_PRESENT;
			end
			cdss_pkg::CDSS_PRESENT: begin
				if (mon_en && !present)
					nxt_card = cdss_pkg::CDSS_ABSENT;
				else if (!mon_en)
					nxt_card = cdss_pkg::CDSS_FROZEN;
			end
			cdss_pkg::CDSS_FROZEN: begin
				if (mon_en)
					nxt_card = present ? cdss_pkg::CDSS_INIT : cdss_pkg::CDSS_ABSENT;
			end
			default: nxt_card = cdss_pkg::CDSS_ABSENT;
		endcase
	end

	wire card_init = nxt_card == cdss_pkg::CDSS_INIT;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			card_ff    <= cdss_pkg::CDSS_ABSENT;
			started_ff <= 1'b0;
			init_ff    <= 1'b0;
		end else begin
			card_ff    <= nxt_card;
			started_ff <= started_ff | read_req | card_init;
			init_ff    <= card_init;
		end
	end

	// ----------------------------------------------------------------
	// Firmware ready
	// ----------------------------------------------------------------
	logic fw_rdy_ff;
	wire  nxt_fw_rdy = boot_ok & ~crashed & ~shutdown;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			fw_rdy_ff <= 1'b0;
		else
			fw_rdy_ff <= nxt_fw_rdy;
	end

	// ----------------------------------------------------------------
	// Message arrival pulse
	// ----------------------------------------------------------------
	logic [31:0] pulse_cnt_ff;
	logic        msg_out_ff;
	wire         pulse_last = pulse_cnt_ff == 32'h00000001;
	wire [31:0]  nxt_pulse_cnt = msg_fire ? 32'(PULSE_CYCLES)
	                           : (msg_out_ff ? pulse_cnt_ff - 32'h00000001 : 32'h00000000);
	wire         nxt_msg_out = msg_fire | (msg_out_ff & ~pulse_last);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pulse_cnt_ff <= 32'h00000000;
			msg_out_ff   <= 1'b0;
		end else begin
			pulse_cnt_ff <= nxt_pulse_cnt;
			msg_out_ff   <= nxt_msg_out;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	wire [cdss_pkg::IRQ_W-1:0] irq_evt = {msg_fire,
		card_ff == cdss_pkg::CDSS_PRESENT && nxt_card == cdss_pkg::CDSS_ABSENT,
		card_init};
	wire [cdss_pkg::IRQ_W-1:0] irq_clr = wr_irq ? pwdata_i[cdss_pkg::IRQ_W-1:0]
	                                            : {cdss_pkg::IRQ_W{1'b0}};
	wire [cdss_pkg::IRQ_W-1:0] nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_evt;
	wire                       nxt_irq = |(nxt_irq_st & irq_mask_ff);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_st_ff   <= {cdss_pkg::IRQ_W{1'b0}};
			irq_mask_ff <= {cdss_pkg::IRQ_W{1'b0}};
			irq_ff      <= 1'b0;
		end else begin
			irq_st_ff   <= nxt_irq_st;
			irq_mask_ff <= wr_mask ? pwdata_i[cdss_pkg::IRQ_W-1:0] : irq_mask_ff;
			irq_ff      <= nxt_irq;
		end
	end

	// ----------------------------------------------------------------
	// Registers and APB answer
	// ----------------------------------------------------------------
	wire [4:0]  nxt_ctrl = wr_ctrl ? pwdata_i[4:0] : ctrl_ff;
	wire [31:0] stat_val = {26'h0000000, msg_out_ff, fw_rdy_ff, card_ff, cd_filt_ff, present};
	wire [31:0] rd_mux   = sel_ctrl ? {27'h0000000, ctrl_ff}
	                     : sel_stat ? stat_val
	                     : sel_irq  ? {29'h00000000, irq_st_ff}
	                     : sel_mask ? {29'h00000000, irq_mask_ff}
	                     : 32'h00000000;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_ff    <= cdss_pkg::CTRL_RST;
			prdata_ff  <= 32'h00000000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			prdata_ff  <= (acc & ~pwrite_i) ? rd_mux : 32'h00000000;
			pready_ff  <= acc;
			pslverr_ff <= acc & ~mapped;
		end
	end

	assign prdata_o                    = prdata_ff;
	assign pready_o                    = pready_ff;
	assign pslverr_o                   = pslverr_ff;
	assign card_init_start_o           = init_ff;
	assign firmware_ready_out_o        = fw_rdy_ff;
	assign message_arrival_pulse_out_o = msg_out_ff;
	assign irq_o                       = irq_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_fw_low_crash: assert property (crashed |=> !fw_rdy_ff)
		else $error("firmware ready high after crash");
	a_fw_low_shut: assert property (shutdown |=> !fw_rdy_ff)
		else $error("firmware ready high after shutdown");
	a_fw_up_boot: assert property (boot_ok && !crashed && !shutdown && $stable(ctrl_ff)
		|=> fw_rdy_ff)
		else $error("firmware ready not high after boot");
	a_msg_start: assert property (msg_fire |=> message_arrival_pulse_out_o)
		else $error("arrival pulse did not start");
	a_msg_cls2: assert property (msg_evt && msg_cls2 && !msg_out_ff
		|=> !message_arrival_pulse_out_o)
		else $error("class 2 message triggered pulse");
	a_msg_len: assert property (msg_out_ff |-> pulse_cnt_ff <= 32'(PULSE_CYCLES))
		else $error("pulse counter out of range");
	a_card_gone: assert property (mon_en && card_ff == cdss_pkg::CDSS_PRESENT && !present
		|=> card_ff == cdss_pkg::CDSS_ABSENT)
		else $error("card not marked removed");
	a_card_frozen: assert property (card_ff == cdss_pkg::CDSS_FROZEN && !mon_en
		|=> !card_init_start_o)
		else $error("card read while monitoring off");
	a_card_init: assert property (mon_en && card_ff == cdss_pkg::CDSS_ABSENT && present
		|=> card_init_start_o)
		else $error("init not started on insert");
	a_init_pulse: assert property (card_init_start_o |=> !card_init_start_o)
		else $error("init start longer than one cycle");
	a_frozen_hold: assert property (card_ff == cdss_pkg::CDSS_FROZEN && !mon_en
		|=> card_ff == cdss_pkg::CDSS_FROZEN)
		else $error("card state left frozen while monitoring off");
	a_filt_hold: assert property (filt_diff && !filt_done |=> cd_filt_ff == $past(cd_filt_ff))
		else $error("detect accepted before filter time");
	a_fw_low_boot: assert property (!boot_ok |=> !fw_rdy_ff)
		else $error("firmware ready high before boot");
	a_msg_end: assert property (msg_out_ff && pulse_last && !msg_fire
		|=> !message_arrival_pulse_out_o)
		else $error("arrival pulse did not end");
	a_msg_idle: assert property (!msg_out_ff && !msg_fire
		|=> !message_arrival_pulse_out_o)
		else $error("arrival pulse without message");

	c_msg_pulse: cover property (msg_fire ##1 message_arrival_pulse_out_o);
	c_insert:    cover property (card_init_start_o);
	c_remove:    cover property (card_ff == cdss_pkg::CDSS_PRESENT
		##1 card_ff == cdss_pkg::CDSS_ABSENT);
	c_fw_up:     cover property (!fw_rdy_ff ##1 fw_rdy_ff);
	c_cls2:      cover property (msg_evt && msg_cls2);

endmodule : cdss_top

// ==== sim/cdss_slot.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Card slot: contact bounce on every change of the settled level
// ----------------------------------------------------------------
module cdss_slot (
	// Clock and wanted level
	input  wire logic mclk_i,
	input  wire logic level_i,
	// Detect pin
	output logic      card_detect_in_o
);
	logic last_ff;
	int   bounce_ff;
	initial begin
		card_detect_in_o = 1'b0;
		last_ff          = 1'b0;
		bounce_ff        = 0;
	end
	always @(posedge mclk_i) begin
		if (level_i !== last_ff) begin
			last_ff   <= level_i;
			bounce_ff <= 3;
		end else if (bounce_ff > 1) begin
			card_detect_in_o <= ~card_detect_in_o;
			bounce_ff        <= bounce_ff - 1;
		end else if (bounce_ff == 1) begin
			card_detect_in_o <= last_ff;
			bounce_ff        <= 0;
		end
	end
endmodule : cdss_slot

// ==== sim/cdss_top_tb.sv ====
`timescale 1ns/1ns
module cdss_top_tb;
	localparam int PULSE = 50;
	logic        mclk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd, rnd;
	logic [3:0]  pstrb_i = 4'hf;
	logic        pready_o, pslverr_o, card_detect_in_i, card_init_start_o, err;
	logic        firmware_ready_out_o, message_arrival_pulse_out_o, irq_o, level = 0;
	int          mismatches = 0, n_checks = 0, cyc = 0, init_cnt = 0, hi_cnt = 0;
	logic        cls2;
	always #5 mclk_i = ~mclk_i;
	cdss_top #(.PULSE_CYCLES(PULSE), .FILT_CYCLES(4)) dut (.mclk_i(mclk_i),
		.resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .card_detect_in_i(card_detect_in_i),
		.card_init_start_o(card_init_start_o), .firmware_ready_out_o(firmware_ready_out_o),
		.message_arrival_pulse_out_o(message_arrival_pulse_out_o), .irq_o(irq_o));
	cdss_slot slot (.mclk_i(mclk_i), .level_i(level), .card_detect_in_o(card_detect_in_i));
	always @(negedge mclk_i) begin
		if (card_init_start_o === 1'b1) init_cnt++;
		if (message_arrival_pulse_out_o === 1'b1) hi_cnt++;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i   <= 1'b1;
		pwrite_i <= wr;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do @(posedge mclk_i); while (pready_o !== 1'b1);
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : settle
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(91275));
		settle(3);
		check("arrival in reset", message_arrival_pulse_out_o, 1'b0);
		check("firmware_ready_out in reset", firmware_ready_out_o, 1'b0);
		@(posedge mclk_i) resetn_i <= 1'b1;
		apb(0, cdss_pkg::CTRL_OFS, 0);
		check("ctrl reset", rd, 32'h1);
		rnd = $urandom;
		apb(1, cdss_pkg::MASK_OFS, rnd);
		apb(0, cdss_pkg::MASK_OFS, 0);
		check("mask readback", rd, rnd & 32'h7);
		apb(0, 12'h0f0, 0);
		check("unmapped err", err, 1'b1);
		$display("register test done");
		apb(1, cdss_pkg::MASK_OFS, 32'h7);
		init_cnt = 0;
		level <= 1'b1;
		settle(40);
		check("init on insert", init_cnt, 1);
		apb(0, cdss_pkg::STAT_OFS, 0);
		check("present", rd[0], 1'b1);
		check("irq insert", irq_o, 1'b1);
		apb(1, cdss_pkg::IRQ_OFS, 32'h7);
		settle(2);
		check("irq cleared", irq_o, 1'b0);
		init_cnt = 0;
		level <= 1'b0;
		settle(40);
		check("no init on removal", init_cnt, 0);
		apb(0, cdss_pkg::IRQ_OFS, 0);
		check("removed flag", rd[1], 1'b1);
		apb(0, cdss_pkg::STAT_OFS, 0);
		check("absent", rd[0], 1'b0);
		apb(1, cdss_pkg::CTRL_OFS, 32'h3);
		settle(40);
		check("init active low", init_cnt, 1);
		apb(0, cdss_pkg::STAT_OFS, 0);
		check("present active low", rd[0], 1'b1);
		$display("card test done");
		check("fw before boot", firmware_ready_out_o, 1'b0);
		apb(1, cdss_pkg::CTRL_OFS, 32'h7);
		settle(2);
		check("fw after boot", firmware_ready_out_o, 1'b1);
		apb(1, cdss_pkg::CTRL_OFS, 32'hf);
		settle(2);
		check("fw on crash", firmware_ready_out_o, 1'b0);
		apb(1, cdss_pkg::CTRL_OFS, 32'h7);
		settle(2);
		apb(1, cdss_pkg::CTRL_OFS, 32'h17);
		settle(2);
		check("fw on shutdown", firmware_ready_out_o, 1'b0);
		$display("firmware test done");
		for (int i = 0; i < 5; i++) begin
			cls2 = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
			hi_cnt = 0;
			apb(1, cdss_pkg::EVT_OFS, {30'h0, cls2, 1'b1});
			settle(PULSE + 20);
			check("pulse length", hi_cnt, cls2 ? 0 : PULSE);
		end
		$display("message test done");
		apb(1, cdss_pkg::EVT_OFS, 32'h1);
		settle(5);
		check("arrival before reset", message_arrival_pulse_out_o, 1'b1);
		resetn_i <= 1'b0;
		settle(2);
		check("arrival in mid reset", message_arrival_pulse_out_o, 1'b0);
		check("fw in mid reset", firmware_ready_out_o, 1'b0);
		check("irq in mid reset", irq_o, 1'b0);
		resetn_i <= 1'b1;
		apb(0, cdss_pkg::CTRL_OFS, 0);
		check("ctrl after reset", rd, 32'h1);
		$display("mid reset test done");
		init_cnt = 0;
		apb(1, cdss_pkg::CTRL_OFS, 32'h2);
		apb(1, cdss_pkg::EVT_OFS, 32'h4);
		check("read once at start", init_cnt, 1);
		init_cnt = 0;
		level <= 1'b1;
		settle(40);
		level <= 1'b0;
		settle(40);
		check("no init when off", init_cnt, 0);
		apb(0, cdss_pkg::STAT_OFS, 0);
		check("frozen state", rd[3:2], 2'b10);
		$display("monitor off test done");
		stop_test();
	end
endmodule : cdss_top_tb
